// file: common/srw_pkg.sv
// shared constants, types and state codes of the supervisor block
// assumes a single 25 MHz system clock and a 32-bit AHB-Lite register port

package srw_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W = 25;
  // reset stretch choices in microseconds (least times, round up)
  localparam int STRETCH_US_0 = 64;
  localparam int STRETCH_US_1 = 128;
  localparam int STRETCH_US_2 = 256;
  localparam int STRETCH_US_3 = 512;
  localparam int STRETCH_CYC_0 = (STRETCH_US_0 * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STRETCH_CYC_1 = (STRETCH_US_1 * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STRETCH_CYC_2 = (STRETCH_US_2 * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STRETCH_CYC_3 = (STRETCH_US_3 * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // watchdog periods in microseconds (longest times, round down)
  localparam int WDOG_US_0 = 1000;
  localparam int WDOG_US_1 = 2000;
  localparam int WDOG_US_2 = 4000;
  localparam int WDOG_US_3 = 8000;
  localparam int WDOG_CYC_0 = WDOG_US_0 * 1000 / CLK_PERIOD_NS;
  localparam int WDOG_CYC_1 = WDOG_US_1 * 1000 / CLK_PERIOD_NS;
  localparam int WDOG_CYC_2 = WDOG_US_2 * 1000 / CLK_PERIOD_NS;
  localparam int WDOG_CYC_3 = WDOG_US_3 * 1000 / CLK_PERIOD_NS;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // control word: low four bits of the control register
  typedef struct packed {
    logic [1:0] stretch_sel;
    logic [1:0] wdog_sel;
  } srw_ctrl_t;

  // status word, bit 0 is sys_reset
  typedef struct packed {
    logic [24:0] zero;
    logic write_protect;
    logic mon_three_low;
    logic mon_two_low;
    logic supply_low;
    logic manual_active;
    logic wdog_timeout;
    logic sys_reset;
  } srw_status_t;

  // ****************************************************************
  // pins and states
  // ****************************************************************
  typedef struct packed {
    logic write_protect;
    logic mon_three_low;
    logic mon_two_low;
    logic supply_low;
    logic manual_reset_n;
  } srw_pins_t;
  localparam logic [4:0] PINS_IDLE = 5'h01;
  localparam logic [1:0] BUS_IDLE = 2'h3;

  typedef enum logic [3:0] {
    WD_IDLE = 4'h1,
    WD_START = 4'h2,
    WD_LOW = 4'h4,
    WD_HIGH = 4'h8
  } srw_wd_state_t;

endpackage

// file: src/srw_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs are slow levels; the first stage feeds only the second

`timescale 1ns/1ps

module srw_sync
  import srw_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // two stages
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

  chk_sync_two_stage: assert property (
    @(posedge clk) disable iff (rst)
    !$past(rst, 1) && !$past(rst, 2) |-> q == $past(d, 2))
    else $error("synchroniser delay is not two cycles");

endmodule

// file: src/srw_top.sv
// supervisor: system reset generation, stretch, watchdog, fail flags,
// write protect gate and an AHB-Lite register slave
// assumes one free-running 25 MHz clock; comparator results, manual
// reset, write protect and bus pins arrive asynchronously
//
// Summary of operation
// - manual reset low asserts system reset
// - reset holds while low, then one stretch
// - supply low or manual reset asserts reset
// - active-low reset output is open drain
// - active-high reset output is push-pull
// - power application asserts reset at once
// - release only after supply good for stretch
// - power-on reset refuses bus transactions
// - start, clocks, stop sequence restarts watchdog
// - no restart before period makes watchdog active
// - watchdog output active low, open drain
// - bus data watched always, never gated
// - write protect high rejects every write
// - third fail pulls low below trip level
// - third fail follows comparator, no stretch
// - early supply low output push-pull, no stretch
// - second fail pulls low below trip, no stretch
// - watchdog period from two control bits
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/1ps

module srw_top
  import srw_pkg::*;
#(
  parameter int unsigned STRETCH_CYC0 = STRETCH_CYC_0,
  parameter int unsigned STRETCH_CYC1 = STRETCH_CYC_1,
  parameter int unsigned STRETCH_CYC2 = STRETCH_CYC_2,
  parameter int unsigned STRETCH_CYC3 = STRETCH_CYC_3,
  parameter int unsigned WDOG_CYC0 = WDOG_CYC_0,
  parameter int unsigned WDOG_CYC1 = WDOG_CYC_1,
  parameter int unsigned WDOG_CYC2 = WDOG_CYC_2,
  parameter int unsigned WDOG_CYC3 = WDOG_CYC_3
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic MANUAL_RESET_N,
  input wire logic SUPPLY_LOW,
  input wire logic MON_TWO_LOW,
  input wire logic MON_THREE_LOW,
  input wire logic WRITE_PROTECT,
  input wire logic SDA_IN,
  input wire logic SCL_IN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  output logic SYS_RESET,
  output logic SYS_RESET_N_O,
  output logic SYS_RESET_N_OE_N,
  output logic WATCHDOG_OUT_N_O,
  output logic WATCHDOG_OUT_N_OE_N,
  output logic MONITOR_FAIL_TWO_N_O,
  output logic MONITOR_FAIL_TWO_N_OE_N,
  output logic MONITOR_FAIL_THREE_N_O,
  output logic MONITOR_FAIL_THREE_N_OE_N,
  output logic EARLY_SUPPLY_LOW_N
);

  srw_pins_t pins_raw;
  srw_pins_t pins_s;
  logic [1:0] bus_s;
  srw_ctrl_t ctrl_q;
  srw_status_t status;
  logic cause;
  logic [CNT_W-1:0] stretch_cnt_q;
  logic [CNT_W-1:0] stretch_load;
  logic sys_rst_d;
  logic sys_rst_q;
  logic rst_oe_n_q;
  logic por_q;
  logic wd_timeout;
  logic od_low_q;
  logic wdo_oe_n_q;
  logic fail2_oe_n_q;
  logic fail3_oe_n_q;
  logic early_low_n_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  logic wr_ok;
  logic [31:0] rd_mux;
  logic [CNT_W:0] quiet_q;
  logic [CNT_W-1:0] last_load_q;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  assign pins_raw.write_protect = WRITE_PROTECT;
  assign pins_raw.mon_three_low = MON_THREE_LOW;
  assign pins_raw.mon_two_low = MON_TWO_LOW;
  assign pins_raw.supply_low = SUPPLY_LOW;
  assign pins_raw.manual_reset_n = MANUAL_RESET_N;

  srw_sync #(
    .W($bits(srw_pins_t)),
    .RST_VAL(PINS_IDLE)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d(pins_raw),
    .q(pins_s)
  );

  // bus lines idle high; synchronised like the comparator, manual reset and write protect pins
  srw_sync #(
    .W(2),
    .RST_VAL(BUS_IDLE)
  ) u_bus_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d({SDA_IN, SCL_IN}),
    .q(bus_s)
  );

  // ****************************************************************
  // reset cause and stretch
  // ****************************************************************
  assign cause = pins_s.supply_low || !pins_s.manual_reset_n;

  always_comb begin
    unique case (ctrl_q.stretch_sel)
      2'h0: stretch_load = CNT_W'(STRETCH_CYC0 - 1);
      2'h1: stretch_load = CNT_W'(STRETCH_CYC1 - 1);
      2'h2: stretch_load = CNT_W'(STRETCH_CYC2 - 1);
      default: stretch_load = CNT_W'(STRETCH_CYC3 - 1);
    endcase
  end

  // reloads while any cause stands, so release needs a clean stretch
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      stretch_cnt_q <= CNT_W'(STRETCH_CYC0 - 1);
    end else if (cause) begin
      stretch_cnt_q <= stretch_load;
    end else if (stretch_cnt_q != '0) begin
      stretch_cnt_q <= stretch_cnt_q - 1'b1;
    end
  end

  assign sys_rst_d = cause || (stretch_cnt_q != '0);

  // both variants come from one decision, so they never disagree
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sys_rst_q <= 1'b1;
      rst_oe_n_q <= 1'b0;
    end else begin
      sys_rst_q <= sys_rst_d;
      rst_oe_n_q <= !sys_rst_d;
    end
  end

  // power-on phase ends at the first release of system reset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      por_q <= 1'b1;
    end else if (!sys_rst_d) begin
      por_q <= 1'b0;
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  srw_wdog #(
    .CYC0(WDOG_CYC0),
    .CYC1(WDOG_CYC1),
    .CYC2(WDOG_CYC2),
    .CYC3(WDOG_CYC3)
  ) u_wdog (
    .clk(CLK_SYS),
    .rst(RST),
    .hold(sys_rst_q),
    .sda(bus_s[1]),
    .scl(bus_s[0]),
    .sel(ctrl_q.wdog_sel),
    .timeout_q(wd_timeout)
  );

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // open-drain levels are always low; only the enables move
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      od_low_q <= 1'b0;
    end else begin
      od_low_q <= 1'b0;
    end
  end

  // flags follow the comparators and the watchdog timeout with no stretch
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wdo_oe_n_q <= 1'b1;
      fail2_oe_n_q <= 1'b1;
      fail3_oe_n_q <= 1'b1;
      early_low_n_q <= 1'b1;
    end else begin
      wdo_oe_n_q <= !wd_timeout;
      fail2_oe_n_q <= !pins_s.mon_two_low;
      fail3_oe_n_q <= !pins_s.mon_three_low;
      early_low_n_q <= !pins_s.supply_low;
    end
  end

  assign SYS_RESET = sys_rst_q;
  assign SYS_RESET_N_O = od_low_q;
  assign SYS_RESET_N_OE_N = rst_oe_n_q;
  assign WATCHDOG_OUT_N_O = od_low_q;
  assign WATCHDOG_OUT_N_OE_N = wdo_oe_n_q;
  assign MONITOR_FAIL_TWO_N_O = od_low_q;
  assign MONITOR_FAIL_TWO_N_OE_N = fail2_oe_n_q;
  assign MONITOR_FAIL_THREE_N_O = od_low_q;
  assign MONITOR_FAIL_THREE_N_OE_N = fail3_oe_n_q;
  assign EARLY_SUPPLY_LOW_N = early_low_n_q;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // address phase capture; reads add one wait state so the read data
  // always reflect a write completed in the cycle before
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hready_q <= 1'b1;
        wr_pend_q <= 1'b0;
      end else if (HREADY) begin
        wr_pend_q <= HSEL && HTRANS[1] && HWRITE;
        rd_pend_q <= HSEL && HTRANS[1] && !HWRITE;
        hready_q <= !(HSEL && HTRANS[1] && !HWRITE);
        if (HSEL && HTRANS[1]) begin
          addr_q <= HADDR[11:0];
        end
      end else begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // writes silently dropped under protection or power-on reset
  assign wr_ok = wr_pend_q && (addr_q == OFS_CTRL)
                 && !pins_s.write_protect
                 && !por_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ok) begin
      ctrl_q <= srw_ctrl_t'(HWDATA[3:0]);
    end
  end

  always_comb begin
    status = '0;
    status.write_protect = pins_s.write_protect;
    status.mon_three_low = pins_s.mon_three_low;
    status.mon_two_low = pins_s.mon_two_low;
    status.supply_low = pins_s.supply_low;
    status.manual_active = !pins_s.manual_reset_n;
    status.wdog_timeout = wd_timeout;
    status.sys_reset = sys_rst_q;
  end

  always_comb begin
    unique case (addr_q)
      OFS_CTRL: rd_mux = {28'h0000000, ctrl_q};
      OFS_STATUS: rd_mux = status;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // reads during power-on reset answer zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= por_q ? 32'h00000000 : rd_mux;
    end
  end

  assign HREADYOUT = hready_q;
  assign HRDATA = hrdata_q;
  assign HRESP = hresp_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  // helper: cycles since the last cause, and the load that was used
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      quiet_q <= '0;
      last_load_q <= CNT_W'(STRETCH_CYC0 - 1);
    end else if (cause) begin
      quiet_q <= '0;
      last_load_q <= stretch_load;
    end else if (!quiet_q[CNT_W]) begin
      quiet_q <= quiet_q + 1'b1;
    end
  end

  chk_manual_asserts: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    !pins_s.manual_reset_n |=> SYS_RESET && !SYS_RESET_N_OE_N)
    else $error("manual reset did not assert system reset");

  chk_manual_stretch: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    $rose(pins_s.manual_reset_n) && !pins_s.supply_low
    |-> stretch_cnt_q == last_load_q ##1 SYS_RESET)
    else $error("reset not held after manual release");

  chk_supply_asserts: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    pins_s.supply_low |=> SYS_RESET)
    else $error("supply low did not assert system reset");

  chk_reset_polarity: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    SYS_RESET == !SYS_RESET_N_OE_N && !SYS_RESET_N_O)
    else $error("reset output variants disagree");

  chk_por_entry: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    $past(RST) |-> SYS_RESET && por_q && !SYS_RESET_N_OE_N)
    else $error("power-on reset not asserted");

  chk_release_time: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    $fell(sys_rst_q) |-> quiet_q == {1'b0, last_load_q} + 1'b1)
    else $error("system reset released before the stretch");

  chk_por_blocks: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    por_q |=> $stable(ctrl_q))
    else $error("register written during power-on reset");

  chk_wp_blocks: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    pins_s.write_protect |=> $stable(ctrl_q))
    else $error("register written while write protected");

  chk_wdog_pin: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    wd_timeout |=> !WATCHDOG_OUT_N_OE_N && !WATCHDOG_OUT_N_O)
    else $error("watchdog pin not pulled low on timeout");

  chk_fail_three: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    ##1 MONITOR_FAIL_THREE_N_OE_N == !$past(pins_s.mon_three_low))
    else $error("third fail pin does not follow comparator");

  chk_fail_two: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    ##1 MONITOR_FAIL_TWO_N_OE_N == !$past(pins_s.mon_two_low))
    else $error("second fail pin does not follow comparator");

  chk_early_low: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    $rose(pins_s.supply_low) |=> !EARLY_SUPPLY_LOW_N)
    else $error("early supply low output late");

  chk_stretch_reload: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    cause |=> stretch_cnt_q == $past(stretch_load))
    else $error("stretch counter not reloaded by a cause");

endmodule

// file: src/srw_wdog.sv
// watchdog: restart sequence detector on the two-wire bus plus timer
// assumes sda and scl already synchronised to clk

`timescale 1ns/1ps

module srw_wdog
  import srw_pkg::*;
#(
  parameter int unsigned CYC0 = WDOG_CYC_0,
  parameter int unsigned CYC1 = WDOG_CYC_1,
  parameter int unsigned CYC2 = WDOG_CYC_2,
  parameter int unsigned CYC3 = WDOG_CYC_3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic sda,
  input wire logic scl,
  input wire logic [1:0] sel,
  output logic timeout_q
);

  srw_wd_state_t state_q;
  logic sda_prev_q;
  logic start_cond;
  logic stop_cond;
  logic kick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load;

  // ****************************************************************
  // restart detection
  // ****************************************************************
  // bus watched at all times, nothing gates these edges
  assign start_cond = scl && sda_prev_q && !sda;
  assign stop_cond = scl && !sda_prev_q && sda;
  assign kick = (state_q == WD_HIGH) && stop_cond;

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_prev_q <= 1'b1;
    end else begin
      sda_prev_q <= sda;
    end
  end

  // start, clock low, clock high, stop; a repeated start restarts it
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= WD_IDLE;
    end else if (start_cond) begin
      state_q <= WD_START;
    end else begin
      unique case (state_q)
        WD_IDLE: state_q <= WD_IDLE;
        WD_START: begin
          if (stop_cond) state_q <= WD_IDLE;
          else if (!scl) state_q <= WD_LOW;
        end
        WD_LOW: begin
          if (scl) state_q <= WD_HIGH;
        end
        WD_HIGH: begin
          if (stop_cond) state_q <= WD_IDLE;
          else if (!scl) state_q <= WD_LOW;
        end
        default: state_q <= WD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // timer
  // ****************************************************************
  // period picked from the two control bits
  always_comb begin
    unique case (sel)
      2'h0: load = CNT_W'(CYC0 - 1);
      2'h1: load = CNT_W'(CYC1 - 1);
      2'h2: load = CNT_W'(CYC2 - 1);
      default: load = CNT_W'(CYC3 - 1);
    endcase
  end

  // held reloaded while system reset is out, so the host gets a full period
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= CNT_W'(CYC0 - 1);
      timeout_q <= 1'b0;
    end else if (kick || hold) begin
      cnt_q <= load;
      timeout_q <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      timeout_q <= 1'b1;
    end
  end

  chk_kick_reloads: assert property (
    @(posedge clk) disable iff (rst)
    kick |=> !timeout_q && cnt_q == $past(load))
    else $error("restart sequence did not reload the watchdog");

  chk_expiry_times_out: assert property (
    @(posedge clk) disable iff (rst)
    cnt_q == '0 && !kick && !hold |=> timeout_q)
    else $error("watchdog expired without timing out");

endmodule

// file: verif/srw_host.sv
// host model: drives the two-wire bus lines toward the supervisor
// assumes bus pull-ups, so released lines read high
`timescale 1ns/1ps
module srw_host (
  input wire logic clk,
  output logic sda,
  output logic scl
);
  // idle bus: both lines released, pulled high
  initial begin
    sda = 1'b1;
    scl = 1'b1;
  end
  // one bus phase; hold of 3 or more clocks survives the synchronisers
  task automatic phase(input logic d, input logic c, input int hold);
    @(posedge clk);
    sda <= d;
    scl <= c;
    repeat (hold) @(posedge clk);
  endtask
  // start, clock low, clock high, stop; clocked 0 drops the clock pulse
  task automatic restart(input bit clocked, input int hold);
    phase(1'b0, 1'b1, hold);
    if (clocked) begin
      phase(1'b0, 1'b0, hold);
      phase(1'b0, 1'b1, hold);
    end
    phase(1'b1, 1'b1, hold);
  endtask
endmodule

// file: verif/supervisor_reset_watchdog_tb.sv
// self-checking bench: reset stretch, fail flags, watchdog, registers
// assumes srw_top with shortened counts and srw_host on the bus pins
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb
  import srw_pkg::*;
;
  localparam int S0 = 8;
  localparam int P0 = 60;
  logic clk = 1'b0, rst = 1'b1, man_n = 1'b1, sup = 1'b0, m2 = 1'b0;
  logic m3 = 1'b0, wp = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, rd;
  logic rdy, resp, sr, sr_o, sr_oe, wd_o, wd_oe, f2_o, f2_oe, f3_o, f3_oe;
  logic esl_n, sda, scl;
  int bad_count = 0, samples_checked = 0, n;

  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  always #20 clk = ~clk;
  srw_top #(.STRETCH_CYC0(S0), .STRETCH_CYC1(S0 + 2), .STRETCH_CYC2(S0 + 4),
    .STRETCH_CYC3(S0 + 6), .WDOG_CYC0(P0), .WDOG_CYC1(P0 + 20),
    .WDOG_CYC2(P0 + 40), .WDOG_CYC3(P0 + 60)) srw_top_inst (
    .CLK_SYS(clk), .RST(rst), .MANUAL_RESET_N(man_n), .SUPPLY_LOW(sup),
    .MON_TWO_LOW(m2), .MON_THREE_LOW(m3), .WRITE_PROTECT(wp), .SDA_IN(sda),
    .SCL_IN(scl), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
    .HREADYOUT(rdy), .HRDATA(rdata), .HRESP(resp), .SYS_RESET(sr),
    .SYS_RESET_N_O(sr_o), .SYS_RESET_N_OE_N(sr_oe),
    .WATCHDOG_OUT_N_O(wd_o), .WATCHDOG_OUT_N_OE_N(wd_oe),
    .MONITOR_FAIL_TWO_N_O(f2_o), .MONITOR_FAIL_TWO_N_OE_N(f2_oe),
    .MONITOR_FAIL_THREE_N_O(f3_o), .MONITOR_FAIL_THREE_N_OE_N(f3_oe),
    .EARLY_SUPPLY_LOW_N(esl_n));
  srw_host srw_host_inst (.clk(clk), .sda(sda), .scl(scl));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
  endtask
  // single word transfer; each phase holds until ready is sampled high
  // no local limit: only the hang guard may end a wait
  task automatic ahb(logic [11:0] a, logic w, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = rdata;
    check("response", 0, resp);
  endtask
  // edges until the system reset is seen low, bounded
  task automatic fall_after(output int k);
    k = 0;
    while (sr !== 1'b0 && k < 300) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic power_on();
    cyc(3);
    check("reset in por", 1, sr);
    check("reset pin in por", 0, sr_oe);
    rst <= 1'b0;
    ahb(OFS_CTRL, 1'b1, 32'hf);
    // status would show the reset bit if the read were not refused
    ahb(OFS_STATUS, 1'b0, 0);
    check("status in por", 0, rd);
    fall_after(n);
    check("por stretch", S0, n + 4);
    ahb(OFS_CTRL, 1'b0, 0);
    check("ctrl after por", 0, rd);
    ahb(OFS_STATUS, 1'b0, 0);
    check("status idle", 0, rd);
  endtask
  task automatic protect();
    ahb(OFS_CTRL, 1'b1, 32'h6);
    wp <= 1'b1;
    cyc(4);
    ahb(OFS_CTRL, 1'b1, 32'h9);
    ahb(OFS_CTRL, 1'b0, 0);
    check("ctrl under protect", 32'h6, rd);
    ahb(OFS_STATUS, 1'b0, 0);
    check("status protect", 32'h40, rd);
    ahb(12'h010, 1'b0, 0);
    check("unmapped", 0, rd);
    wp <= 1'b0;
    // let the synchronised protect level drop before the next write
    cyc(4);
  endtask
  // every stretch select, measured from the manual release
  task automatic manual();
    for (int s = 0; s < 4; s++) begin
      ahb(OFS_CTRL, 1'b1, s << 2);
      man_n <= 1'b0;
      cyc(4);
      check("reset on manual", 1, sr);
      check("pin on manual", 0, sr_oe);
      cyc(10);
      check("reset held", 1, sr);
      man_n <= 1'b1;
      fall_after(n);
      check("stretch", S0 + 2 * s + 3, n);
      check("pin released", 1, sr_oe);
    end
  endtask
  task automatic supply();
    sup <= 1'b1;
    cyc(4);
    check("reset on supply", 1, sr);
    check("early low", 0, esl_n);
    sup <= 1'b0;
    cyc(4);
    check("early low gone", 1, esl_n);
    check("reset still", 1, sr);
    fall_after(n);
    check("supply stretch", S0 + 5, n);
  endtask
  task automatic monitors();
    m2 <= 1'b1;
    cyc(4);
    check("fail two", 0, f2_oe);
    check("fail three", 1, f3_oe);
    m2 <= 1'b0;
    m3 <= 1'b1;
    cyc(4);
    check("fail two gone", 1, f2_oe);
    check("fail three on", 0, f3_oe);
    m3 <= 1'b0;
    cyc(4);
    check("fail three gone", 1, f3_oe);
    check("drive levels", 0, {sr_o, wd_o, f2_o, f3_o});
    check("no reset", 0, sr);
  endtask
  // each period select; a stop with no clock pulse must not restart
  task automatic watchdog();
    for (int s = 0; s < 4; s++) begin
      ahb(OFS_CTRL, 1'b1, s);
      srw_host_inst.restart(1'b1, 3);
      cyc(P0 + 20 * s - 10);
      check("wd before period", 1, wd_oe);
      srw_host_inst.restart(1'b0, 3 + s);
      cyc(20);
      check("wd timed out", 0, wd_oe);
    end
    srw_host_inst.restart(1'b1, 6);
    cyc(4);
    check("wd restarted", 1, wd_oe);
  endtask

  // main sequence, then verdict
  initial begin
    power_on();
    protect();
    manual();
    supply();
    monitors();
    watchdog();
    stop_test();
  end
  // hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    cyc(20000);
    bad_count++;
    stop_test();
  end
endmodule
